// >>> pkg/vecint_pkg.sv
// How it works
// (RL1) Vector table fills the lowest 12 program bytes, two per request.
// (RL2) Entry pushes PC low byte, then PC high byte, then the flags.
// (RL3) The entry sequence clears the serviced request's pending bit.
// (RL4) The entry sequence clears the global enable, mask bit 7.
// (RL5) The handler address is read from program bytes 2x and 2x+1.
// (RL6) Byte at 2x is the address high half, 2x+1 the low half.
// (RL7) Among enabled pending requests the highest ranked one is taken.
// (RL8) Service return pops flags then PC and sets the global enable.
// (RL9) Flags pop plus plain return restores state, mask left unchanged.
// (RL10) Masked or globally disabled requests still set readable pending bits.
// (RL11) Software polling clears the pending bit it services.
// (RL12) Software polls requests in descending priority order.
// (RL13) Nesting handlers save mask, mask lower sources, then re-enable.
// (RL14) Software disables globally before changing the source mask.
// (RL15) A request is enabled only with its mask bit and bit 7 set.
// (RL16) After reset pending stays zero until the first enable-all op.
// (RL17) Disable-all clears bit 7; a later mask register write may set it.
// (RL18) Each push decrements the stack pointer, then writes there.
// (RL19) Requests are sampled at instruction boundaries, before next fetch.
// (RL20) Pending bits stay set until entry sequence or software clears them.
`default_nettype none
package vecint_pkg;
  localparam int NUM_SRC = 6;
  localparam int VEC_BYTES = 12;
  localparam logic [15:0] VEC_BASE = 16'h0000;
  localparam int GBIT = 7;

  localparam logic [2:0] OFF_PEND = 3'h0;
  localparam logic [2:0] OFF_MASK = 3'h1;
  localparam logic [2:0] OFF_PRIO = 3'h2;
  localparam logic [2:0] OFF_SPHI = 3'h3;
  localparam logic [2:0] OFF_SPLO = 3'h4;
  localparam logic [2:0] OFF_STAT = 3'h5;

  localparam logic [5:0] PEND_RST = 6'h00;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [7:0] PRIO_RST = 8'h00;
  localparam logic [15:0] SP_RST = 16'h0000;

  typedef struct packed {
    logic        we;
    logic        re;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } vecint_dmem_t;

  typedef enum logic [3:0] {
    ST_IDLE, ST_PUSH, ST_VEC_A, ST_VEC_B, ST_VEC_HI, ST_VEC_LO,
    ST_POP_ISSUE, ST_POP_WAIT, ST_POP_TAKE
  } vecint_state_t;

  // Rank 0 is the top; out-of-range tops fall back to source 0
  function automatic logic [2:0] vecint_rank(input logic [2:0] id,
                                             input logic [2:0] top);
    logic [2:0] t;
    t = (top > 3'(NUM_SRC - 1)) ? 3'h0 : top;
    vecint_rank = (id >= t) ? 3'(id - t) : 3'(id + 3'(NUM_SRC) - t);
  endfunction

  function automatic logic [5:0] vecint_onehot(input logic [2:0] id);
    vecint_onehot = 6'(7'h01 << id);
  endfunction
endpackage
`default_nettype wire

// >>> rtl/vecint_pick.sv
`timescale 1ns/1ps
`default_nettype none
module vecint_pick #(
  parameter int NSRC = vecint_pkg::NUM_SRC
) (
  input  wire logic [NSRC-1:0] en,
  input  wire logic [2:0]      top,
  output logic                 valid,
  output logic [2:0]           id
);
  import vecint_pkg::*;

  always_comb begin
    logic [2:0] best;
    best = 3'h7;
    valid = 1'b0;
    id = 3'h0;
    for (int j = 0; j < NSRC; j++) begin
      if (en[j] && (vecint_rank(3'(j), top) < best)) begin // RL7
        best = vecint_rank(3'(j), top);
        id = 3'(j);
        valid = 1'b1;
      end
    end
  end
endmodule // vecint_pick
`default_nettype wire

// >>> rtl/vecint_unit.sv
// Decided for this implementation: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module vecint_unit (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic [2:0]           reg_addr,
  input  wire logic [7:0]           reg_wdata,
  input  wire logic                 reg_we,
  input  wire logic                 reg_re,
  output logic [7:0]                reg_rdata,
  input  wire logic [5:0]           irq_req,
  input  wire logic                 insn_boundary,
  input  wire logic                 enable_all_op,
  input  wire logic                 disable_all_op,
  input  wire logic                 service_return_op,
  input  wire logic                 plain_return_op,
  input  wire logic [15:0]          pc_now,
  input  wire logic [7:0]           flags_now,
  output vecint_pkg::vecint_dmem_t  dmem,
  input  wire logic [7:0]           dmem_rdata,
  output logic                      pmem_rd,
  output logic [15:0]               pmem_addr,
  input  wire logic [7:0]           pmem_rdata,
  output logic                      busy,
  output logic                      pc_load,
  output logic [15:0]               pc_value,
  output logic                      flags_load,
  output logic [7:0]                flags_value
);
  import vecint_pkg::*;

  vecint_state_t st_q, st_d;
  logic [5:0]   pend_q, pend_d;
  logic [7:0]   mask_q, mask_d;
  logic [7:0]   prio_q;
  logic [15:0]  sp_q, sp_d;
  logic         armed_q;
  logic [2:0]   src_q;
  logic [1:0]   idx_q;
  logic [15:0]  spc_q;
  logic [7:0]   sflg_q;
  logic [7:0]   vhi_q;
  vecint_dmem_t dmem_q;
  logic [7:0]   rdata_q;
  logic         pmem_rd_q;
  logic [15:0]  pmem_addr_q;
  logic         busy_q;
  logic         pc_load_q;
  logic [15:0]  pc_value_q;
  logic         flags_load_q;
  logic [7:0]   flags_value_q;

  wire       idle     = (st_q == ST_IDLE);
  wire       wr_pend  = reg_we && (reg_addr == OFF_PEND);
  wire       wr_mask  = reg_we && (reg_addr == OFF_MASK);
  wire       wr_prio  = reg_we && (reg_addr == OFF_PRIO);
  wire       wr_sphi  = reg_we && (reg_addr == OFF_SPHI);
  wire       wr_splo  = reg_we && (reg_addr == OFF_SPLO);
  wire [5:0] en_req   = pend_q & mask_q[5:0] & {6{mask_q[GBIT]}}; // RL15
  wire       pick_valid;
  wire [2:0] pick_id;

  vecint_pick #(
    .NSRC(NUM_SRC)
  ) u_pick (
    .en    (en_req),
    .top   (prio_q[2:0]),
    .valid (pick_valid),
    .id    (pick_id)
  );

  // Only at a boundary, so the core never fetches past a taken request
  wire take     = idle && insn_boundary && pick_valid; // RL19
  wire ret_go   = idle && !take && (service_return_op || plain_return_op);
  wire service_return_op_go  = ret_go && service_return_op;
  wire [5:0] clr_vec = take ? vecint_onehot(pick_id) : 6'h00; // RL3
  wire [5:0] pend_base = wr_pend ? reg_wdata[5:0] : pend_q;
  wire [7:0] mask_base = wr_mask ? reg_wdata : mask_q;
  wire       push_now  = (st_q == ST_PUSH);
  wire       pop_now   = (st_q == ST_POP_ISSUE);
  wire [7:0] push_byte = (idx_q == 2'h0) ? spc_q[7:0] :
                         (idx_q == 2'h1) ? spc_q[15:8] : sflg_q; // RL2
  wire [15:0] vec_addr = VEC_BASE + {12'h000, src_q, 1'b0}; // RL1 RL5
  wire [7:0] stat_val  = {busy_q, armed_q, 3'h0, src_q};
  wire [7:0] rd_mux =
    (reg_addr == OFF_PEND) ? {2'h0, pend_q} :
    (reg_addr == OFF_MASK) ? mask_q :
    (reg_addr == OFF_PRIO) ? prio_q :
    (reg_addr == OFF_SPHI) ? sp_q[15:8] :
    (reg_addr == OFF_SPLO) ? sp_q[7:0] :
    (reg_addr == OFF_STAT) ? stat_val : 8'h00;

  // Sources win over clears so no request is dropped on a clear
  assign pend_d = armed_q ? ((pend_base & ~clr_vec) | irq_req) // RL10 RL20
                          : PEND_RST; // RL16

  always_comb begin
    mask_d = mask_base;
    if (take || disable_all_op) begin
      mask_d[GBIT] = 1'b0; // RL4 RL17
    end else if (enable_all_op || service_return_op_go) begin
      mask_d[GBIT] = 1'b1; // RL8 RL17
    end
  end

  // Sequencer owns the pointer while it pushes or pops
  always_comb begin
    sp_d = sp_q;
    if (push_now) begin
      sp_d = sp_q - 16'h0001; // RL18
    end else if (pop_now) begin
      sp_d = sp_q + 16'h0001;
    end else if (wr_sphi) begin
      sp_d = {reg_wdata, sp_q[7:0]};
    end else if (wr_splo) begin
      sp_d = {sp_q[15:8], reg_wdata};
    end
  end

  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_IDLE: begin
        if (take) begin
          st_d = ST_PUSH;
        end else if (ret_go) begin
          st_d = ST_POP_ISSUE;
        end
      end
      ST_PUSH:      st_d = (idx_q == 2'h2) ? ST_VEC_A : ST_PUSH;
      ST_VEC_A:     st_d = ST_VEC_B;
      ST_VEC_B:     st_d = ST_VEC_HI;
      ST_VEC_HI:    st_d = ST_VEC_LO;
      ST_VEC_LO:    st_d = ST_IDLE;
      ST_POP_ISSUE: st_d = ST_POP_WAIT;
      ST_POP_WAIT:  st_d = ST_POP_TAKE;
      ST_POP_TAKE:  st_d = (idx_q == 2'h2) ? ST_IDLE : ST_POP_ISSUE;
      default:      st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= ST_IDLE;
      pend_q <= PEND_RST;
      mask_q <= MASK_RST;
      prio_q <= PRIO_RST;
      sp_q <= SP_RST;
      armed_q <= 1'b0;
    end else begin
      st_q <= st_d;
      pend_q <= pend_d;
      mask_q <= mask_d;
      prio_q <= wr_prio ? reg_wdata : prio_q;
      sp_q <= sp_d;
      armed_q <= armed_q | enable_all_op; // RL16
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
      busy_q <= 1'b0;
    end else begin
      rdata_q <= reg_re ? rd_mux : 8'h00;
      busy_q <= (st_d != ST_IDLE);
    end
  end

  // Context capture and sequence index
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      src_q <= 3'h0;
      idx_q <= 2'h0;
      spc_q <= 16'h0000;
      sflg_q <= 8'h00;
    end else if (take) begin
      src_q <= pick_id;
      idx_q <= 2'h0;
      spc_q <= pc_now;
      sflg_q <= flags_now;
    end else if (ret_go) begin
      idx_q <= service_return_op_go ? 2'h0 : 2'h1; // RL8 RL9
    end else if (push_now || (st_q == ST_POP_TAKE)) begin
      idx_q <= 2'(idx_q + 2'h1);
    end
  end

  // Data memory strobes: push writes at the new pointer, pop reads old
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dmem_q <= '0;
    end else begin
      dmem_q.we <= push_now;
      dmem_q.re <= pop_now;
      dmem_q.addr <= push_now ? sp_d : sp_q; // RL18
      dmem_q.wdata <= push_now ? push_byte : 8'h00; // RL2
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pmem_rd_q <= 1'b0;
      pmem_addr_q <= 16'h0000;
      vhi_q <= 8'h00;
    end else begin
      pmem_rd_q <= (st_q == ST_VEC_A) || (st_q == ST_VEC_B);
      pmem_addr_q <= (st_q == ST_VEC_B) ? 16'(vec_addr + 16'h0001)
                                        : vec_addr; // RL5
      vhi_q <= (st_q == ST_VEC_HI) ? pmem_rdata : vhi_q;
    end
  end

  // Core loads: vectored jump or popped context
  wire pop_take = (st_q == ST_POP_TAKE);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pc_load_q <= 1'b0;
      pc_value_q <= 16'h0000;
      flags_load_q <= 1'b0;
      flags_value_q <= 8'h00;
    end else begin
      pc_load_q <= (st_q == ST_VEC_LO) || (pop_take && (idx_q == 2'h2));
      flags_load_q <= pop_take && (idx_q == 2'h0); // RL8
      if (st_q == ST_VEC_LO) begin
        pc_value_q <= {vhi_q, pmem_rdata}; // RL6
      end else if (pop_take && (idx_q == 2'h1)) begin
        pc_value_q <= {dmem_rdata, pc_value_q[7:0]};
      end else if (pop_take && (idx_q == 2'h2)) begin
        pc_value_q <= {pc_value_q[15:8], dmem_rdata};
      end
      if (pop_take && (idx_q == 2'h0)) begin
        flags_value_q <= dmem_rdata;
      end
    end
  end

  assign reg_rdata = rdata_q;
  assign dmem = dmem_q;
  assign pmem_rd = pmem_rd_q;
  assign pmem_addr = pmem_addr_q;
  assign busy = busy_q;
  assign pc_load = pc_load_q;
  assign pc_value = pc_value_q;
  assign flags_load = flags_load_q;
  assign flags_value = flags_value_q;

  // Checks
  logic beaten;
  always_comb begin
    beaten = 1'b0;
    for (int j = 0; j < NUM_SRC; j++) begin
      if (en_req[j] &&
          (vecint_rank(3'(j), prio_q[2:0]) < vecint_rank(pick_id, prio_q[2:0])))
      begin
        beaten = 1'b1;
      end
    end
  end

  a_hold_pending: assert property (@(posedge clk) disable iff (!rst_n) // RL16
    !armed_q |-> pend_q == 6'h00)
    else $error("pending set before first enable-all");

  a_push_order: assert property (@(posedge clk) disable iff (!rst_n) // RL2
    take |-> ##2 (dmem.we && dmem.wdata == $past(pc_now[7:0], 2))
      ##1 (dmem.we && dmem.wdata == $past(pc_now[15:8], 3))
      ##1 (dmem.we && dmem.wdata == $past(flags_now, 4)))
    else $error("entry push order wrong");

  a_sp_predec: assert property (@(posedge clk) disable iff (!rst_n) // RL18
    dmem.we |-> (dmem.addr == sp_q) && (sp_q == 16'($past(sp_q) - 16'h0001)))
    else $error("push not at decremented pointer");

  a_take_clears: assert property (@(posedge clk) disable iff (!rst_n) // RL3
    take && !irq_req[pick_id] |=> !pend_q[$past(pick_id)])
    else $error("serviced pending bit not cleared");

  a_take_global: assert property (@(posedge clk) disable iff (!rst_n) // RL4
    take |=> !mask_q[GBIT])
    else $error("global enable not cleared on entry");

  a_take_enabled: assert property (@(posedge clk) disable iff (!rst_n) // RL15
    take |-> mask_q[GBIT] && mask_q[pick_id] && !beaten) // RL7
    else $error("request taken while not enabled or not highest");

  a_vec_fetch: assert property (@(posedge clk) disable iff (!rst_n) // RL5
    take |-> ##5 (pmem_rd && pmem_addr == {12'h000, $past(pick_id, 5), 1'b0})
      ##1 (pmem_rd && pmem_addr == {12'h000, $past(pick_id, 6), 1'b1}))
    else $error("vector fetch address wrong");

  a_vec_join: assert property (@(posedge clk) disable iff (!rst_n) // RL6
    take |-> ##8 (pc_load && pc_value ==
                  {$past(pmem_rdata, 2), $past(pmem_rdata, 1)}))
    else $error("vector word assembled wrongly");

  a_service_return_op_global: assert property (@(posedge clk) disable iff (!rst_n) // RL8
    service_return_op_go && !disable_all_op |=> mask_q[GBIT] ##3 flags_load ##3 !pc_load
      ##3 pc_load)
    else $error("service return sequence wrong");

  a_ret_keeps: assert property (@(posedge clk) disable iff (!rst_n) // RL9
    ret_go && !service_return_op_go && !wr_mask && !enable_all_op && !disable_all_op
      |=> mask_q == $past(mask_q))
    else $error("plain return changed the mask");

  a_req_caught: assert property (@(posedge clk) disable iff (!rst_n) // RL10
    armed_q |=> (pend_q & $past(irq_req)) == $past(irq_req))
    else $error("request lost while armed");

  a_pend_sticky: assert property (@(posedge clk) disable iff (!rst_n) // RL20
    armed_q && !take && !wr_pend |=> (pend_q & $past(pend_q)) == $past(pend_q))
    else $error("pending bit dropped without clear");

  a_disable_all: assert property (@(posedge clk) disable iff (!rst_n) // RL17
    disable_all_op |=> !mask_q[GBIT])
    else $error("disable-all left global enable set");

  a_boundary: assert property (@(posedge clk) disable iff (!rst_n) // RL19
    $rose(busy) && $past(st_d) == ST_PUSH |-> $past(insn_boundary))
    else $error("entry started off a boundary");

  a_entry_busy: assert property (@(posedge clk) disable iff (!rst_n) // RL19
    take |=> busy [*7] ##1 !busy)
    else $error("busy not held through entry");

  a_plain_ret: assert property (@(posedge clk) disable iff (!rst_n) // RL9
    ret_go && !service_return_op_go |-> ##2 dmem.re ##3 dmem.re ##2 pc_load)
    else $error("plain return sequence wrong");

  a_pop_order: assert property (@(posedge clk) disable iff (!rst_n) // RL8
    service_return_op_go && !wr_sphi && !wr_splo
      |-> ##2 (dmem.re && dmem.addr == $past(sp_q, 2))
      ##3 (dmem.re && dmem.addr == 16'($past(sp_q, 5) + 16'h0001)))
    else $error("service return pops wrong addresses");

  a_rdata_idle: assert property (@(posedge clk) disable iff (!rst_n) // strobed register read, decided for this implementation
    !reg_re |=> reg_rdata == 8'h00)
    else $error("read data stands outside its cycle");

  c_vectored: cover property (@(posedge clk) disable iff (!rst_n)
    take ##8 pc_load);
  c_service_return_op: cover property (@(posedge clk) disable iff (!rst_n)
    service_return_op_go ##10 pc_load);
  c_two_pending: cover property (@(posedge clk) disable iff (!rst_n)
    take && $countones(en_req) > 1);
  c_plain: cover property (@(posedge clk) disable iff (!rst_n)
    ret_go && !service_return_op_go ##7 pc_load);
endmodule // vecint_unit
`default_nettype wire

// >>> verification/vecint_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module vecint_mem_model (
  input  wire logic                     clk,
  input  wire vecint_pkg::vecint_dmem_t dmem,
  input  wire logic                     pmem_rd,
  input  wire logic [15:0]              pmem_addr,
  output logic [7:0]                    dmem_rdata,
  output logic [7:0]                    pmem_rdata
);
  import vecint_pkg::*;
  logic [7:0] stack_q [0:255];
  initial begin
    dmem_rdata = 8'h00;
    pmem_rdata = 8'h00;
  end
  // Released buses flip so a stale byte never passes for fresh data
  always @(posedge clk) begin
    if (dmem.we) stack_q[dmem.addr[7:0]] <= dmem.wdata;
    dmem_rdata <= dmem.re ? stack_q[dmem.addr[7:0]] : ~dmem_rdata;
    pmem_rdata <= pmem_rd ? (pmem_addr[7:0] ^ 8'ha5) : ~pmem_rdata;
  end
endmodule // vecint_mem_model
`default_nettype wire

// >>> verification/test_vecint_unit.sv
`timescale 1ns/1ps
`default_nettype none
module test_vecint_unit;
  import vecint_pkg::*;
  localparam logic [3:0] K_RD = 4'h1, K_WR = 4'h2, K_PM = 4'h3;
  localparam logic [3:0] K_PC = 4'h4, K_FL = 4'h5;
  localparam logic [4:0] B_BND = 5'h01, B_EN = 5'h02, B_DIS = 5'h04;
  localparam logic [4:0] B_SRET = 5'h08, B_PRET = 5'h10;
  logic         clk, rst_n, reg_we, reg_re, busy, pmem_rd;
  logic         pc_load, flags_load, rd_seen;
  logic [2:0]   reg_addr;
  logic [7:0]   reg_wdata, reg_rdata, flags_now, flags_value;
  logic [7:0]   dmem_rdata, pmem_rdata, fl;
  logic [5:0]   irq_req, p, hm;
  logic [4:0]   ops;
  logic [15:0]  pc_now, pc_value, pmem_addr, pc;
  vecint_dmem_t dmem;
  logic [31:0]  exp_q [$];
  int           failures, samples_checked, cycles, t, x;

  vecint_unit u_vecint_unit (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
    .irq_req(irq_req), .insn_boundary(ops[0]), .enable_all_op(ops[1]),
    .disable_all_op(ops[2]), .service_return_op(ops[3]),
    .plain_return_op(ops[4]), .pc_now(pc_now), .flags_now(flags_now),
    .dmem(dmem), .dmem_rdata(dmem_rdata), .pmem_rd(pmem_rd),
    .pmem_addr(pmem_addr), .pmem_rdata(pmem_rdata), .busy(busy),
    .pc_load(pc_load), .pc_value(pc_value), .flags_load(flags_load),
    .flags_value(flags_value));
  vecint_mem_model u_vecint_mem_model (
    .clk(clk), .dmem(dmem), .pmem_rd(pmem_rd), .pmem_addr(pmem_addr),
    .dmem_rdata(dmem_rdata), .pmem_rdata(pmem_rdata));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic print_verdict;
    $display("failures=%0d samples_checked=%0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  function automatic void note(input logic [3:0] k, input logic [15:0] a,
                               input logic [7:0] d);
    exp_q.push_back({k, 4'h0, a, d});
  endfunction

  // Empty queue yields an unknown note, so a stray result always fails
  task automatic take(input string nm, input logic [31:0] g);
    logic [31:0] e;
    e = (exp_q.size() > 0) ? exp_q.pop_front() : 32'hx;
    check(nm, e, g);
  endtask

  always @(negedge clk) begin
    if (rd_seen) take("reg_rdata", {K_RD, 20'h0, reg_rdata});
    if (dmem.we) take("push", {K_WR, 4'h0, dmem.addr, dmem.wdata});
    if (pmem_rd) take("vec_fetch", {K_PM, 4'h0, pmem_addr, 8'h00});
    if (pc_load) take("pc_value", {K_PC, 4'h0, pc_value, 8'h00});
    if (flags_load) take("flags", {K_FL, 20'h0, flags_value});
    rd_seen = reg_re;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      print_verdict();
    end
  end

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_we <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, input logic [7:0] d);
    note(K_RD, 16'h0, d);
    @(posedge clk);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_re <= 1'b0;
  endtask

  task automatic pulse(input logic [4:0] o);
    @(posedge clk);
    ops <= o;
    @(posedge clk);
    ops <= 5'h00;
  endtask

  task automatic irq(input logic [5:0] v);
    @(posedge clk);
    irq_req <= v;
    @(posedge clk);
    irq_req <= 6'h00;
  endtask

  task automatic wait_idle;
    int n;
    n = 0;
    repeat (3) @(posedge clk);
    #1;
    while (busy !== 1'b0 && n < 40) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask

  initial begin
    void'($urandom(32'he5503390));
    {rst_n, reg_we, reg_re, reg_addr, reg_wdata, irq_req, ops} = '0;
    {pc_now, flags_now, rd_seen} = '0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    for (int a = 0; a < 8; a++) rd(3'(a), 8'h00);
    irq(6'h3f);
    rd(OFF_PEND, 8'h00);
    wr(OFF_MASK, 8'h80);
    wr(OFF_PEND, 8'h3f);
    irq(6'h3f);
    rd(OFF_PEND, 8'h00);
    pulse(B_EN);
    rd(OFF_MASK, 8'h80);
    rd(OFF_STAT, 8'h40);
    pulse(B_DIS);
    rd(OFF_MASK, 8'h00);
    wr(OFF_MASK, 8'h80);
    rd(OFF_MASK, 8'h80);
    pulse(B_DIS);
    irq(6'h15);
    rd(OFF_PEND, 8'h15);
    wr(OFF_PEND, 8'h14);
    rd(OFF_PEND, 8'h14);
    for (int i = 0; i < 2; i++) begin
      wr(OFF_MASK, (i != 0) ? 8'h80 : 8'h3f);
      pulse(B_BND);
      repeat (2) @(posedge clk);
      #1;
      check("busy_off", 32'h0, 32'(busy));
    end
    for (int k = 0; k < 6; k++) begin
      pulse(B_DIS);
      wr(OFF_PEND, 8'h00);
      t = $urandom % 8;
      wr(OFF_PRIO, 8'(t));
      rd(OFF_PRIO, 8'(t));
      // Tops past the last source rank like source 0
      if (t > 5) t = 0;
      wr(OFF_SPHI, 8'h00);
      wr(OFF_SPLO, 8'h40);
      p = 6'($urandom % 63 + 1);
      irq(p);
      x = -1;
      for (int i = 0; i < 6; i++)
        if (x < 0 && p[(t + i) % 6]) x = (t + i) % 6;
      pc = 16'($urandom);
      fl = 8'($urandom);
      pc_now <= pc;
      flags_now <= fl;
      wr(OFF_MASK, 8'hbf);
      repeat (4) begin
        @(posedge clk);
        #1;
        check("busy_early", 32'h0, 32'(busy));
      end
      note(K_WR, 16'h003f, pc[7:0]);
      note(K_WR, 16'h003e, pc[15:8]);
      note(K_WR, 16'h003d, fl);
      note(K_PM, 16'(2 * x), 8'h00);
      note(K_PM, 16'(2 * x + 1), 8'h00);
      note(K_PC, {8'(2 * x) ^ 8'ha5, 8'(2 * x + 1) ^ 8'ha5}, 8'h00);
      pulse(B_BND);
      wait_idle();
      rd(OFF_PEND, {2'b00, p & ~(6'h01 << x)});
      rd(OFF_MASK, 8'h3f);
      rd(OFF_SPLO, 8'h3d);
      // Nest: only sources ranked above the served one stay unmasked
      hm = 6'h00;
      for (int i = 0; i < 6; i++)
        if (i < (x - t + 6) % 6) hm[(t + i) % 6] = 1'b1;
      wr(OFF_MASK, {2'b00, hm});
      pulse(B_EN);
      pulse(B_BND);
      repeat (2) @(posedge clk);
      #1;
      check("busy_nest", 32'h0, 32'(busy));
      pulse(B_DIS);
      wr(OFF_MASK, 8'h3f);
      if (k % 2 == 0) begin
        note(K_FL, 16'h0, fl);
        note(K_PC, pc, 8'h00);
        pulse(B_SRET);
        wait_idle();
        rd(OFF_MASK, 8'hbf);
      end else begin
        wr(OFF_SPLO, 8'h3e);
        note(K_PC, pc, 8'h00);
        pulse(B_PRET);
        wait_idle();
        rd(OFF_MASK, 8'h3f);
      end
      rd(OFF_SPLO, 8'h40);
    end
    repeat (4) @(posedge clk);
    check("notes_left", 32'h0, 32'(exp_q.size()));
    print_verdict();
  end
endmodule // test_vecint_unit
`default_nettype wire
